// File: src/pos_params.svh
// Register offsets, field positions, address width and reset values.
// Assumes inclusion by the PWM output stage and its package users.
`ifndef POS_PARAMS_SVH
`define POS_PARAMS_SVH

`define POS_ADDR_W          8
`define POS_OFS_CTRL        8'h00
`define POS_OFS_TIMING      8'h04
`define POS_OFS_DEADBAND    8'h08
`define POS_OFS_STEER_SEL   8'h0C
`define POS_OFS_STEER_CTRL  8'h10
`define POS_OFS_BURST       8'h14
`define POS_OFS_SD_CTRL     8'h18
`define POS_OFS_SD_SOURCE   8'h1C
`define POS_OFS_SD_LEVEL    8'h20
`define POS_OFS_SYNC        8'h24
`define POS_OFS_STATUS      8'h28

// Control register fields
`define POS_CTRL_EN         0
`define POS_CTRL_LD         1
`define POS_CTRL_MODE_LO    2
`define POS_CTRL_MODE_HI    3
`define POS_CTRL_DBR_EN     4
`define POS_CTRL_DBF_EN     5
// Burst control fields
`define POS_BURST_EN        0
`define POS_BURST_SOFT      1
`define POS_BURST_SRC_LO    4
`define POS_BURST_SRC_HI    5
`define POS_BURST_IDX_LO    8
`define POS_BURST_IDX_HI    9
// Shutdown control fields
`define POS_SD_EN           0
`define POS_SD_FLAG         1
`define POS_SD_OVR          2
`define POS_SD_AUTO         3
`define POS_SD_ACTIVE       4

`define POS_RST_PERIOD      16'h00FF
`define POS_RST_DUTY        16'h0080
`define POS_RST_ZERO        32'h0000_0000

`endif

// File: src/pos_pkg.sv
// Types shared by the PWM output stage.
// Assumes pos_params.svh defines all numeric constants.
package pos_pkg;

  typedef enum logic [1:0] {
    POS_MODE_SINGLE = 2'b00,
    POS_MODE_COMPL  = 2'b01,
    POS_MODE_FIXED  = 2'b10,
    POS_MODE_3PH    = 2'b11
  } pos_mode_t;

  typedef enum logic [1:0] {
    POS_SRC_PIN  = 2'b00,
    POS_SRC_CCP  = 2'b01,
    POS_SRC_CMP  = 2'b10,
    POS_SRC_SOFT = 2'b11
  } pos_src_t;

  typedef enum logic [1:0] {
    POS_RUN      = 2'b00,
    POS_STOPPING = 2'b01,
    POS_FROZEN   = 2'b10
  } pos_run_t;

  typedef struct packed {
    logic       burst_input_pin;
    logic [1:0] ccp_out;
    logic [3:0] cmp_out;
    logic [3:0] sd_in;
    logic [2:0] peer_sync;
  } pos_pins_t;

  typedef struct packed {
    logic [5:0] level;
    logic       sync_out;
    logic       sd_event;
  } pos_outs_t;

endpackage

// File: src/pos_top.sv
// PWM output stage: dead band, steering, burst, auto-shutdown, sync.
// Assumes a single AHB-Lite master and asynchronous pin inputs.
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "pos_params.svh"

module pos_top (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Event sources and peer sync
  input  wire pos_pkg::pos_pins_t pins,
  // Driver outputs, sync out and shutdown event pulse
  output pos_pkg::pos_outs_t     outs
);

  // Input synchroniser
  pos_pkg::pos_pins_t pin_s1;
  pos_pkg::pos_pins_t pin_s2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
    end
  end

  // Software registers
  logic                module_enable_bit;
  logic                buffer_load_request;
  pos_pkg::pos_mode_t  mode;
  logic                dbr_en;
  logic                dbf_en;
  logic [15:0]         period_reg;
  logic [15:0]         duty_reg;
  logic [7:0]          dbr_reg;
  logic [7:0]          dbf_reg;
  logic [5:0]          steer_select_reg;
  logic                steer_sync_enable;
  logic                burst_enable;
  logic                burst_soft_bit;
  pos_pkg::pos_src_t   burst_src;
  logic [1:0]          burst_idx;
  logic                shutdown_enable;
  logic                shutdown_event_flag;
  logic                pin_override_enable;
  logic                auto_restart_enable;
  logic [3:0]          shutdown_source_reg;
  logic [5:0]          shutdown_level_reg;
  logic [1:0]          sync_source_select;

  // Buffered copies
  logic [15:0]         period_buf;
  logic [15:0]         duty_buf;
  logic [7:0]          dbr_buf;
  logic [7:0]          dbf_buf;
  logic [5:0]          steer_buf;

  // Core state
  logic [15:0]         period_timer;
  logic                pwm_raw;
  logic                pri_o;
  logic                comp_o;
  logic [7:0]          dbr_cnt;
  logic [7:0]          dbf_cnt;
  logic                db_freeze;
  pos_pkg::pos_run_t   run_state;
  logic                shutdown_active_flag;
  logic                mod_prev;

  // Bus address phase
  logic                wr_pend;
  logic [7:0]          wr_addr;
  logic                addr_ok;
  logic                wr_now;
  logic                ld_set_now;
  logic                en_set_now;
  assign addr_ok    = hsel && htrans[1] && hready;
  assign wr_now     = wr_pend;
  assign ld_set_now = wr_now && (wr_addr == `POS_OFS_CTRL) && hwdata[`POS_CTRL_LD];
  assign en_set_now = wr_now && (wr_addr == `POS_OFS_CTRL) && hwdata[`POS_CTRL_EN]
                      && !module_enable_bit;

  // Burst source pick, exactly one at a time
  logic mod_src;
  always_comb begin
    unique case (burst_src)
      pos_pkg::POS_SRC_PIN:  mod_src = pin_s2.burst_input_pin;
      pos_pkg::POS_SRC_CCP:  mod_src = pin_s2.ccp_out[burst_idx[0]];
      pos_pkg::POS_SRC_CMP:  mod_src = pin_s2.cmp_out[burst_idx];
      pos_pkg::POS_SRC_SOFT: mod_src = burst_soft_bit;
    endcase
  end
  logic mod_on;
  assign mod_on = !burst_enable || mod_src;

  // Period event: own rollover or selected master sync
  logic master_sync;
  logic own_roll;
  logic mod_start;
  logic period_event;
  assign master_sync  = (sync_source_select != 2'h0)
                        && pin_s2.peer_sync[sync_source_select - 2'h1];
  assign own_roll     = (sync_source_select == 2'h0) && (period_timer >= period_buf);
  assign mod_start    = module_enable_bit && mod_on && !mod_prev;
  assign period_event = module_enable_bit && (run_state != pos_pkg::POS_FROZEN)
                        && (own_roll || master_sync);

  // Shutdown condition, level sensitive
  logic sd_cond;
  assign sd_cond = shutdown_enable && |(shutdown_source_reg & pin_s2.sd_in);

  // Bus write capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_enable_bit   <= 1'b0;
      mode                <= pos_pkg::POS_MODE_SINGLE;
      dbr_en              <= 1'b0;
      dbf_en              <= 1'b0;
      period_reg          <= `POS_RST_PERIOD;
      duty_reg            <= `POS_RST_DUTY;
      dbr_reg             <= 8'h00;
      dbf_reg             <= 8'h00;
      steer_select_reg    <= 6'h00;
      steer_sync_enable   <= 1'b0;
      burst_enable        <= 1'b0;
      burst_soft_bit      <= 1'b0;
      burst_src           <= pos_pkg::POS_SRC_PIN;
      burst_idx           <= 2'h0;
      shutdown_enable     <= 1'b0;
      pin_override_enable <= 1'b0;
      auto_restart_enable <= 1'b0;
      shutdown_source_reg <= 4'h0;
      shutdown_level_reg  <= 6'h00;
      sync_source_select  <= 2'h0;
    end else if (wr_now) begin
      unique case (wr_addr)
        `POS_OFS_CTRL: begin
          module_enable_bit <= hwdata[`POS_CTRL_EN];
          mode              <= pos_pkg::pos_mode_t'(hwdata[`POS_CTRL_MODE_HI:`POS_CTRL_MODE_LO]);
          dbr_en            <= hwdata[`POS_CTRL_DBR_EN];
          dbf_en            <= hwdata[`POS_CTRL_DBF_EN];
        end
        `POS_OFS_TIMING: begin
          period_reg <= hwdata[15:0];
          duty_reg   <= hwdata[31:16];
        end
        `POS_OFS_DEADBAND: begin
          dbr_reg <= hwdata[7:0];
          dbf_reg <= hwdata[15:8];
        end
        `POS_OFS_STEER_SEL:  steer_select_reg  <= hwdata[5:0];
        `POS_OFS_STEER_CTRL: steer_sync_enable <= hwdata[0];
        `POS_OFS_BURST: begin
          burst_enable   <= hwdata[`POS_BURST_EN];
          burst_soft_bit <= hwdata[`POS_BURST_SOFT];
          burst_src      <= pos_pkg::pos_src_t'(hwdata[`POS_BURST_SRC_HI:`POS_BURST_SRC_LO]);
          burst_idx      <= hwdata[`POS_BURST_IDX_HI:`POS_BURST_IDX_LO];
        end
        `POS_OFS_SD_CTRL: begin
          shutdown_enable     <= hwdata[`POS_SD_EN];
          pin_override_enable <= hwdata[`POS_SD_OVR];
          auto_restart_enable <= hwdata[`POS_SD_AUTO];
        end
        `POS_OFS_SD_SOURCE: shutdown_source_reg <= hwdata[3:0];
        `POS_OFS_SD_LEVEL:  shutdown_level_reg  <= hwdata[5:0];
        `POS_OFS_SYNC:      sync_source_select  <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // Load request, cleared by hardware after the transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffer_load_request <= 1'b0;
    end else if (ld_set_now) begin
      buffer_load_request <= 1'b1;
    end else if (buffer_load_request && (period_event || !module_enable_bit)) begin
      buffer_load_request <= 1'b0;
    end
  end

  // Timing buffers: direct while disabled, at period event after load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_buf <= `POS_RST_PERIOD;
      duty_buf   <= `POS_RST_DUTY;
      dbr_buf    <= 8'h00;
      dbf_buf    <= 8'h00;
    end else if (!module_enable_bit || (period_event && buffer_load_request)) begin
      period_buf <= period_reg;
      duty_buf   <= duty_reg;
      dbr_buf    <= dbr_reg;
      dbf_buf    <= dbf_reg;
    end
  end

  // Steering buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      steer_buf <= 6'h00;
    end else if (en_set_now || (ld_set_now && !steer_sync_enable)) begin
      steer_buf <= steer_select_reg;
    end else if (period_event && buffer_load_request) begin
      steer_buf <= steer_select_reg;
    end
  end

  // Burst run state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_state <= pos_pkg::POS_FROZEN;
      mod_prev  <= 1'b0;
    end else begin
      mod_prev <= module_enable_bit && mod_on;
      unique case (run_state)
        pos_pkg::POS_RUN: begin
          if (!module_enable_bit) begin
            run_state <= pos_pkg::POS_FROZEN;
          end else if (!mod_on) begin
            run_state <= pos_pkg::POS_STOPPING;
          end
        end
        pos_pkg::POS_STOPPING: begin
          if (!module_enable_bit) begin
            run_state <= pos_pkg::POS_FROZEN;
          end else if (mod_on) begin
            run_state <= pos_pkg::POS_RUN;
          end else if (period_event && (mode != pos_pkg::POS_MODE_FIXED || pwm_raw)) begin
            run_state <= pos_pkg::POS_FROZEN;
          end
        end
        pos_pkg::POS_FROZEN: begin
          if (mod_start) begin
            run_state <= pos_pkg::POS_RUN;
          end
        end
        default: run_state <= pos_pkg::POS_FROZEN;
      endcase
    end
  end

  // Period timer and raw PWM
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_timer <= 16'h0000;
      pwm_raw      <= 1'b0;
    end else if (mod_start) begin
      period_timer <= 16'h0000;
      pwm_raw      <= 1'b1;
    end else if (period_event) begin
      period_timer <= 16'h0000;
      pwm_raw      <= (mode == pos_pkg::POS_MODE_FIXED) ? !pwm_raw : 1'b1;
    end else if (run_state != pos_pkg::POS_FROZEN) begin
      period_timer <= period_timer + 16'h0001;
      if (mode != pos_pkg::POS_MODE_FIXED && period_timer == duty_buf) begin
        pwm_raw <= 1'b0;
      end
    end else begin
      pwm_raw <= 1'b0;
    end
  end

  // Dead band with same-edge overlap restart
  logic prev_raw;
  logic rise_ev;
  logic fall_ev;
  logic dbr_busy;
  logic dbf_busy;
  assign rise_ev  = pwm_raw && !prev_raw;
  assign fall_ev  = !pwm_raw && prev_raw;
  assign dbr_busy = dbr_cnt != 8'h00;
  assign dbf_busy = dbf_cnt != 8'h00;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_raw  <= 1'b0;
      dbr_cnt   <= 8'h00;
      dbf_cnt   <= 8'h00;
      db_freeze <= 1'b0;
      pri_o     <= 1'b0;
      comp_o    <= 1'b0;
    end else begin
      prev_raw <= pwm_raw;
      if (rise_ev && dbr_en) begin
        dbr_cnt   <= dbr_buf;
        dbf_cnt   <= 8'h00;
        db_freeze <= dbr_busy;
      end else if (fall_ev && dbf_en) begin
        dbf_cnt   <= dbf_buf;
        dbr_cnt   <= 8'h00;
        db_freeze <= dbf_busy;
      end else begin
        if (dbr_busy) begin
          dbr_cnt <= dbr_cnt - 8'h01;
        end
        if (dbf_busy) begin
          dbf_cnt <= dbf_cnt - 8'h01;
        end
        if ((dbr_cnt <= 8'h01) && (dbf_cnt <= 8'h01)) begin
          db_freeze <= 1'b0;
        end
      end
      if (!db_freeze && !(rise_ev && dbr_en && dbr_busy) && !(fall_ev && dbf_en && dbf_busy)) begin
        pri_o  <= pwm_raw && !(dbr_en && (rise_ev || dbr_cnt > 8'h01));
        comp_o <= !pwm_raw && (run_state != pos_pkg::POS_FROZEN)
                  && !(dbf_en && (fall_ev || dbf_cnt > 8'h01));
      end
    end
  end

  // Steering
  logic [5:0] steer_eff;
  logic [5:0] steered;
  logic [5:0] ph_sel;
  assign steer_eff = steer_sync_enable ? steer_buf : steer_select_reg;
  assign ph_sel    = steer_eff & (~steer_eff + 6'h01);
  always_comb begin
    steered = 6'h00;
    unique case (mode)
      pos_pkg::POS_MODE_SINGLE: steered = steer_eff & {6{pri_o}};
      pos_pkg::POS_MODE_COMPL, pos_pkg::POS_MODE_FIXED: begin
        steered[0] = steer_eff[0] & pri_o;
        steered[1] = steer_eff[1] & comp_o;
        steered[2] = steer_eff[2] & pri_o;
        steered[3] = steer_eff[3] & comp_o;
        steered[4] = (steer_eff[4] & pri_o) | (steer_eff[5] & comp_o);
      end
      pos_pkg::POS_MODE_3PH: begin
        steered[0] = pri_o & (ph_sel[0] | ph_sel[1]);
        steered[1] = pri_o & (ph_sel[3] | ph_sel[4]);
        steered[2] = pri_o & (ph_sel[2] | ph_sel[3]);
        steered[3] = pri_o & (ph_sel[0] | ph_sel[5]);
        steered[4] = pri_o & (ph_sel[4] | ph_sel[5]);
        steered[5] = pri_o & (ph_sel[1] | ph_sel[2]);
      end
    endcase
  end

  // Shutdown flag and active hold
  logic sw_flag_wr;
  logic sw_flag_val;
  assign sw_flag_wr  = wr_now && (wr_addr == `POS_OFS_SD_CTRL);
  assign sw_flag_val = hwdata[`POS_SD_FLAG];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shutdown_event_flag <= 1'b0;
    end else if (!shutdown_enable) begin
      shutdown_event_flag <= 1'b0;
    end else if (sd_cond || (sw_flag_wr && sw_flag_val)) begin
      shutdown_event_flag <= 1'b1;
    end else if (auto_restart_enable || (sw_flag_wr && !sw_flag_val)) begin
      shutdown_event_flag <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shutdown_active_flag <= 1'b0;
    end else if (shutdown_event_flag) begin
      shutdown_active_flag <= 1'b1;
    end else if (period_event || !shutdown_enable || !module_enable_bit) begin
      shutdown_active_flag <= 1'b0;
    end
  end

  // Output stage
  logic override;
  logic flag_prev;
  assign override = shutdown_enable
                    && (shutdown_active_flag || shutdown_event_flag || pin_override_enable);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outs      <= '0;
      flag_prev <= 1'b0;
    end else begin
      flag_prev     <= shutdown_event_flag;
      outs.sd_event <= shutdown_event_flag && !flag_prev;
      outs.sync_out <= period_event;
      if (override) begin
        outs.level <= shutdown_level_reg;
      end else if (run_state == pos_pkg::POS_FROZEN) begin
        outs.level <= 6'h00;
      end else begin
        outs.level <= steered;
      end
    end
  end

  // Bus read and response
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `POS_RST_ZERO;
    unique case (haddr[7:0])
      `POS_OFS_CTRL:       rd_mux = {26'h0, dbf_en, dbr_en, mode, buffer_load_request,
                                     module_enable_bit};
      `POS_OFS_TIMING:     rd_mux = {duty_reg, period_reg};
      `POS_OFS_DEADBAND:   rd_mux = {16'h0, dbf_reg, dbr_reg};
      `POS_OFS_STEER_SEL:  rd_mux = {26'h0, steer_select_reg};
      `POS_OFS_STEER_CTRL: rd_mux = {31'h0, steer_sync_enable};
      `POS_OFS_BURST:      rd_mux = {22'h0, burst_idx, 2'h0, burst_src, 2'h0,
                                     burst_soft_bit, burst_enable};
      `POS_OFS_SD_CTRL:    rd_mux = {27'h0, shutdown_active_flag, auto_restart_enable,
                                     pin_override_enable, shutdown_event_flag,
                                     shutdown_enable};
      `POS_OFS_SD_SOURCE:  rd_mux = {28'h0, shutdown_source_reg};
      `POS_OFS_SD_LEVEL:   rd_mux = {26'h0, shutdown_level_reg};
      `POS_OFS_SYNC:       rd_mux = {30'h0, sync_source_select};
      `POS_OFS_STATUS:     rd_mux = {period_timer, 6'h0, run_state, outs.level, comp_o, pri_o};
      default:             rd_mux = `POS_RST_ZERO;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= `POS_RST_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

endmodule

// File: tb/pos_gate_model.sv
// Gate driver stand-in counting out_a turn-on edges.
// Assumes level[0] drives the out_a switch.
`timescale 1ns/100ps
module pos_gate_model (
  // Drive
  input  wire logic       hclk,
  input  wire logic [5:0] level,
  // Observation
  output int              a_edges
);
  logic prev = 1'b0;
  initial a_edges = 0;
  always @(posedge hclk) begin
    prev <= level[0];
    if (level[0] && !prev)
      a_edges <= a_edges + 1;
  end
endmodule

// File: tb/pos_top_properties.sv
// Port checker of the PWM output stage.
// Assumes binding onto pos_top; snoops shutdown writes.
`timescale 1ns/100ps
`include "pos_params.svh"
module pos_top_properties (
  // Bus
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [31:0]        hwdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // Pins
  input wire pos_pkg::pos_pins_t pins,
  input wire pos_pkg::pos_outs_t outs
);
  logic       wr_q;
  logic [7:0] wa_q;
  logic [5:0] lvl;
  logic [3:0] src;
  logic [4:0] sdc;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl <= 6'h00;
      src <= 4'h0;
      sdc <= 5'h00;
    end else if (wr_q && hready) begin
      if (wa_q == `POS_OFS_SD_LEVEL)
        lvl <= hwdata[5:0];
      if (wa_q == `POS_OFS_SD_SOURCE)
        src <= hwdata[3:0];
      if (wa_q == `POS_OFS_SD_CTRL)
        sdc <= hwdata[4:0];
    end
  end
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not OKAY");
  a_sd_pulse: assert property (outs.sd_event |=> !outs.sd_event)
    else $error("sd_event longer than one cycle");
  a_sync_pulse: assert property (outs.sync_out |=> !outs.sync_out)
    else $error("sync_out longer than one cycle");
  a_sd_gated: assert property (!sdc[0] && !$past(sdc[0]) && !$past(sdc[0], 2)
    |-> !outs.sd_event) else $error("shutdown event while disabled");
  a_sd_input: assert property ((sdc[0] && |(pins.sd_in & src)) [*6]
    |-> outs.level == lvl) else $error("input shutdown level wrong");
  a_pin_override: assert property ((sdc[0] && sdc[2]) [*4]
    |-> outs.level == lvl) else $error("override level wrong");
  a_soft_flag: assert property ((sdc[0] && sdc[1] && !sdc[3]) [*4]
    |-> outs.level == lvl) else $error("soft shutdown level wrong");
endmodule
bind pos_top pos_top_properties i_pos_top_properties (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .outs(outs));

// File: tb/pos_top_tb.sv
// Self-checking bench of the PWM output stage.
// Assumes pos_top as a zero-wait AHB-Lite slave.
`timescale 1ns/100ps
`include "pos_params.svh"
module pos_top_tb;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0000_0000;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [31:0]        hwdata = 32'h0000_0000;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  pos_pkg::pos_pins_t pins = '0;
  pos_pkg::pos_outs_t outs;
  int                 fails = 0;
  int                 check_count = 0;
  int                 cycles = 0;
  int                 a_edges;
  logic               sd_seen = 1'b0;
  logic [31:0]        rd;
  always #5 hclk = ~hclk;
  pos_top i_pos_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .outs(outs));
  pos_gate_model i_pos_gate_model (.hclk(hclk), .level(outs.level), .a_edges(a_edges));
  always @(posedge hclk) begin
    if (outs.sd_event === 1'b1)
      sd_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic test_regs();
    bus(1'b0, `POS_OFS_TIMING, 32'h0);
    check(rd, {`POS_RST_DUTY, `POS_RST_PERIOD});
    bus(1'b0, 8'h3C, 32'h0);
    check(rd, 32'h0000_0000);
    $display("test_regs done");
  endtask
  task automatic test_steer();
    logic [31:0] tbl [4] = '{32'h0001_2D2D, 32'h0001_1212, 32'h0005_3F1F, 32'h000D_0621};
    logic        bad;
    logic        seen;
    bus(1'b1, `POS_OFS_STEER_SEL, 32'h2D);
    bus(1'b1, `POS_OFS_TIMING, 32'h0004_0009);
    bus(1'b1, `POS_OFS_CTRL, 32'h1);
    foreach (tbl[i]) begin
      bus(1'b1, `POS_OFS_CTRL, {16'h0000, tbl[i][31:16]});
      bus(1'b1, `POS_OFS_STEER_SEL, {24'h0, tbl[i][15:8]});
      @(posedge hclk);
      bad = 1'b0;
      seen = 1'b0;
      repeat (40) begin
        @(posedge hclk);
        bad = bad | ((outs.level & ~tbl[i][5:0]) != 6'h00);
        seen = seen | (outs.level != 6'h00);
      end
      check(bad, 1'b0);
      check(seen, 1'b1);
    end
    check(a_edges > 2, 1'b1);
    $display("test_steer done");
  endtask
  task automatic test_sync();
    logic hit_e;
    bus(1'b1, `POS_OFS_STEER_SEL, 32'h20);
    bus(1'b1, `POS_OFS_STEER_CTRL, 32'h1);
    @(posedge hclk);
    hit_e = 1'b0;
    repeat (30) begin
      @(posedge hclk);
      hit_e = hit_e | outs.level[4];
    end
    check(hit_e, 1'b0);
    bus(1'b1, `POS_OFS_CTRL, 32'hF);
    repeat (30) begin
      @(posedge hclk);
      hit_e = hit_e | outs.level[4];
    end
    check(hit_e, 1'b1);
    bus(1'b0, `POS_OFS_CTRL, 32'h0);
    check(rd[1], 1'b0);
    $display("test_sync done");
  endtask
  task automatic test_burst();
    bus(1'b1, `POS_OFS_BURST, 32'h31);
    repeat (30) @(posedge hclk);
    check(outs.level, 6'h00);
    bus(1'b0, `POS_OFS_STATUS, 32'h0);
    check(rd[9:8], pos_pkg::POS_FROZEN);
    bus(1'b1, `POS_OFS_BURST, 32'h33);
    repeat (5) @(posedge hclk);
    check(outs.level[4], 1'b1);
    $display("test_burst done");
  endtask
  task automatic test_peer();
    bus(1'b1, `POS_OFS_SYNC, 32'h1);
    repeat (20) @(posedge hclk);
    bus(1'b0, `POS_OFS_STATUS, 32'h0);
    check(rd[31:16] > 16'h0009, 1'b1);
    pins.peer_sync <= 3'h1;
    @(posedge hclk);
    pins.peer_sync <= 3'h0;
    repeat (3) @(posedge hclk);
    bus(1'b0, `POS_OFS_STATUS, 32'h0);
    check(rd[31:16] < 16'h0004, 1'b1);
    $display("test_peer done");
  endtask
  task automatic test_ext();
    bus(1'b1, `POS_OFS_SD_LEVEL, 32'h15);
    bus(1'b1, `POS_OFS_SD_SOURCE, 32'h2);
    bus(1'b1, `POS_OFS_SD_CTRL, 32'h9);
    sd_seen = 1'b0;
    pins.sd_in <= 4'h2;
    repeat (30) @(posedge hclk);
    check(sd_seen, 1'b1);
    check(outs.level, 6'h15);
    bus(1'b0, `POS_OFS_SD_CTRL, 32'h0);
    check(rd[1], 1'b1);
    pins.sd_in <= 4'h0;
    repeat (30) @(posedge hclk);
    bus(1'b0, `POS_OFS_SD_CTRL, 32'h0);
    check(rd[1], 1'b0);
    $display("test_ext done");
  endtask
  task automatic test_manual();
    bus(1'b1, `POS_OFS_SD_CTRL, 32'h1);
    pins.sd_in <= 4'h2;
    repeat (10) @(posedge hclk);
    bus(1'b1, `POS_OFS_SD_CTRL, 32'h1);
    bus(1'b0, `POS_OFS_SD_CTRL, 32'h0);
    check(rd[1], 1'b1);
    pins.sd_in <= 4'h0;
    repeat (20) @(posedge hclk);
    bus(1'b0, `POS_OFS_SD_CTRL, 32'h0);
    check(rd[1], 1'b1);
    bus(1'b1, `POS_OFS_SD_CTRL, 32'h1);
    bus(1'b0, `POS_OFS_SD_CTRL, 32'h0);
    check(rd[1], 1'b0);
    sd_seen = 1'b0;
    bus(1'b1, `POS_OFS_SD_CTRL, 32'h3);
    repeat (5) @(posedge hclk);
    check(sd_seen, 1'b1);
    check(outs.level, 6'h15);
    bus(1'b1, `POS_OFS_SD_CTRL, 32'h1);
    $display("test_manual done");
  endtask
  task automatic test_ovr();
    sd_seen = 1'b0;
    bus(1'b1, `POS_OFS_SD_CTRL, 32'h5);
    repeat (5) @(posedge hclk);
    check(outs.level, 6'h15);
    check(sd_seen, 1'b0);
    bus(1'b1, `POS_OFS_SD_CTRL, 32'h0);
    pins.sd_in <= 4'h2;
    repeat (10) @(posedge hclk);
    check(sd_seen, 1'b0);
    bus(1'b0, `POS_OFS_SD_CTRL, 32'h0);
    check(rd[1], 1'b0);
    pins.sd_in <= 4'h0;
    $display("test_ovr done");
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_regs();
    test_steer();
    test_sync();
    test_ext();
    test_manual();
    test_ovr();
    test_burst();
    test_peer();
    stop_test();
  end
endmodule
